// file: core/wake_ctrl_defs.vh
`ifndef WAKE_CTRL_DEFS_VH
`define WAKE_CTRL_DEFS_VH

// =====================================================================
// Register offsets on the serial interface (seven-bit address field).
// =====================================================================
`define ADDR_WDOG_CONFIG 7'h03
`define ADDR_XCVR_MODE 7'h04
`define ADDR_INT_WAKE 7'h06
`define ADDR_EXT_WAKE 7'h07

// =====================================================================
// Reset values after power-on or soft reset.
// =====================================================================
`define RST_WDOG_CONFIG 8'h14
`define RST_XCVR_MODE 8'h00
`define RST_INT_WAKE 8'h00
`define RST_EXT_WAKE 8'h01
// Transceiver field loaded on power-on or soft reset in development mode.
`define DEV_XCVR_MODE 3'h3

// =====================================================================
// Field positions and masks.
// =====================================================================
`define WD_CHECKSUM_BIT 7
`define WD_STOP_LO_BIT 6
`define WD_WINDOW_BIT 5
`define WD_BUS_WAKE_BIT 4
`define WD_PERIOD_HI 2
// Bits that hold storage; reserved positions are masked to zero.
`define MASK_WDOG_CONFIG 8'hF7
`define MASK_XCVR_MODE 8'h07
`define MASK_INT_WAKE 8'h44
`define MASK_EXT_WAKE 8'hA1
// Restart keeps bits 7, 5, 4 and loads 0100 into the low nibble.
`define RESTART_KEEP_WDOG 8'hB0
`define RESTART_SET_WDOG 8'h04
`define RESTART_KEEP_INT 8'h40
`define RESTART_KEEP_EXT 8'hA1
`define IWK_TIMER_BIT 6
`define IWK_STOP_HI_BIT 2
`define EWK_GLOBAL_BIT 7
`define EWK_SENSE_BIT 5
`define EWK_ENABLE_BIT 0
`define SELWAKE_BIT 2

// =====================================================================
// Transceiver mode encodings (low two bits).
// =====================================================================
`define XCVR_OFF 2'h0
`define XCVR_WAKE_CAPABLE 2'h1
`define XCVR_RX_ONLY 2'h2
`define XCVR_NORMAL 2'h3

// =====================================================================
// Serial frame layout: 16 bits, least significant bit first.
// =====================================================================
`define FRAME_BITS 5'h10
`define ADDR_BITS 5'h08
`define WRITE_FLAG_BIT 7
`define STATUS_BYTE 8'h00
// Idle levels of chip select, clock and data, in that order.
`define PIN_IDLE 3'h4

`endif

// file: core/pin_filter.v
`timescale 1ns/10ps
`default_nettype none

// =====================================================================
// Three-stage pin synchroniser with agreement filter.
// =====================================================================
// A pin change is accepted only once the second and third stages agree.
// The first stage is read by the second stage alone.
module pin_filter
#(
    parameter WIDTH = 3,
    // Levels loaded by reset; they must match the idle bus.
    parameter [WIDTH-1:0] IDLE = {WIDTH{1'b1}}
)
(
    input wire CLK,
    input wire ARST_N,
    input wire [WIDTH-1:0] PIN_IN,
    output reg [WIDTH-1:0] PIN_OUT
);

    reg [WIDTH-1:0] stage1_r; // Metastability catcher.
    reg [WIDTH-1:0] stage2_r; // Second stage.
    reg [WIDTH-1:0] stage3_r; // Third stage, compared with the second.
    integer i;

    // Shift the pins in and update a bit only where stages two and three
    // agree; reset loads the idle levels so no false edge follows it.
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            stage1_r <= IDLE;
            stage2_r <= IDLE;
            stage3_r <= IDLE;
            PIN_OUT <= IDLE;
        end
        else
        begin
            stage1_r <= PIN_IN;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            for (i = 0; i < WIDTH; i = i + 1)
            begin
                if (stage2_r[i] == stage3_r[i])
                    PIN_OUT[i] <= stage3_r[i];
            end
        end
    end

endmodule // pin_filter

`default_nettype wire

// file: core/wake_ctrl_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "wake_ctrl_defs.vh"

module wake_ctrl_regs
(
    input wire CLK,
    input wire ARST_N,
    // Serial interface pins to and from the microcontroller.
    input wire SPI_CS_N,
    input wire SPI_SCK,
    input wire SPI_SDI,
    output reg SPI_SDO,
    output reg SPI_SDO_OE_N,
    // Mode transition strobes from the device mode controller.
    input wire SOFT_RESET,
    input wire RESTART_ENTRY,
    input wire [2:0] RESTART_XCVR_MODE,
    input wire FAILSAFE_ENTRY,
    input wire SLEEP_ENTRY,
    input wire STOP_ENTRY,
    input wire STOP_TO_NORMAL,
    input wire SYSTEM_ERROR_FLAG,
    input wire DEV_MODE,
    // Event sources.
    input wire BUS_WAKE_EVENT,
    input wire TIMER_WAKE_EVENT,
    input wire WAKE_PIN_EVENT,
    input wire STATUS_PENDING,
    input wire WAKE_PENDING,
    // Configuration outputs.
    output reg WDOG_WINDOW_SELECT,
    output reg [2:0] WDOG_PERIOD_SELECT,
    output reg WDOG_STOP_DISABLE,
    output reg WDOG_BUS_WAKE_START,
    output reg WDOG_PARITY_ERROR,
    output reg [2:0] XCVR_MODE,
    output reg TIMER_WAKE,
    output reg WAKE_PIN_WAKE,
    output reg WAKE_PIN_SENSE_ON,
    output reg INTERRUPT_OUT_N
);

    // =================================================================
    // Declarations.
    // =================================================================
    reg [7:0] wdog_config_r; // Watchdog configuration storage.
    reg [7:0] xcvr_mode_r; // Transceiver mode storage.
    reg [7:0] int_wake_r; // Internal wake source storage.
    reg [7:0] ext_wake_r; // External wake source storage.
    reg [7:0] wdog_config_nxt;
    reg [7:0] xcvr_mode_nxt;
    reg [7:0] int_wake_nxt;
    reg [7:0] ext_wake_nxt;
    reg init_done_r; // Low until the first edge after reset release.
    reg sck_last_r; // Filtered clock of the previous cycle.
    reg [4:0] bit_cnt_r; // Bits received in the current frame.
    reg [15:0] rx_r; // Received frame, least significant bit first.
    reg [7:0] tx_r; // Data byte returned in the second half.
    reg cs_last_r; // Filtered chip select of the previous cycle.
    wire [2:0] pins_clean; // Filtered chip select, clock and data.
    wire cs_n_f;
    wire sck_f;
    wire sdi_f;
    wire sck_rise;
    wire sck_fall;
    wire frame_end;
    wire write_ok;
    wire [6:0] wr_addr;
    wire [7:0] wr_data;
    wire [7:0] status_byte; // Fixed first byte of every answer.

    // Parity of a byte; one means odd.
    function odd_parity;
        input [7:0] value;
        begin
            odd_parity = ^value;
        end
    endfunction

    // Readback of a register; reserved bits are masked to zero.
    function [7:0] read_reg;
        input [6:0] addr;
        input [7:0] wd;
        input [7:0] xm;
        input [7:0] iw;
        input [7:0] ew;
        begin
            case (addr)
                `ADDR_WDOG_CONFIG: read_reg = wd & `MASK_WDOG_CONFIG;
                `ADDR_XCVR_MODE: read_reg = xm & `MASK_XCVR_MODE;
                `ADDR_INT_WAKE: read_reg = iw & `MASK_INT_WAKE;
                `ADDR_EXT_WAKE: read_reg = ew & `MASK_EXT_WAKE;
                default: read_reg = 8'h00;
            endcase
        end
    endfunction

    // =================================================================
    // Pin synchronisation.
    // =================================================================
    // All three serial pins are asynchronous to CLK, so each is filtered.
    // The clock resets low, as it idles, so no edge is seen after reset.
    pin_filter #(.WIDTH(3), .IDLE(`PIN_IDLE)) u_pins
    (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .PIN_IN({SPI_CS_N, SPI_SCK, SPI_SDI}),
        .PIN_OUT(pins_clean)
    );

    assign cs_n_f = pins_clean[2];
    assign sck_f = pins_clean[1];
    assign sdi_f = pins_clean[0];
    assign sck_rise = !cs_n_f && sck_f && !sck_last_r;
    assign sck_fall = !cs_n_f && !sck_f && sck_last_r;
    // A frame takes effect only when at least sixteen bits were seen; clock edges after the sixteenth are ignored.
    assign frame_end = cs_n_f && !cs_last_r && (bit_cnt_r == `FRAME_BITS);
    assign wr_addr = rx_r[6:0];
    assign wr_data = rx_r[15:8];
    assign write_ok = frame_end && rx_r[`WRITE_FLAG_BIT];
    assign status_byte = `STATUS_BYTE;

    // =================================================================
    // Serial shift engine.
    // =================================================================
    // Data is sampled on the rising clock and driven on the falling one.
    // The data byte returned is the register content before this frame.
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            sck_last_r <= 1'b0;
            cs_last_r <= 1'b1;
            bit_cnt_r <= 5'h00;
            rx_r <= 16'h0000;
            tx_r <= 8'h00;
            SPI_SDO <= 1'b0;
            SPI_SDO_OE_N <= 1'b1;
        end
        else
        begin
            sck_last_r <= sck_f;
            cs_last_r <= cs_n_f;
            // The output only drives while the device is selected.
            SPI_SDO_OE_N <= cs_n_f;
            if (cs_n_f)
            begin
                bit_cnt_r <= 5'h00;
                SPI_SDO <= 1'b0;
            end
            else if (sck_rise && bit_cnt_r < `FRAME_BITS)
            begin
                rx_r[bit_cnt_r[3:0]] <= sdi_f;
                bit_cnt_r <= bit_cnt_r + 5'h01;
                // Address is complete after the eighth bit.
                if (bit_cnt_r == `ADDR_BITS - 5'h01)
                begin
                    tx_r <= read_reg(rx_r[6:0], wdog_config_r,
                        xcvr_mode_r, int_wake_r, ext_wake_r);
                end
            end
            else if (sck_fall)
            begin
                if (bit_cnt_r < `ADDR_BITS)
                    SPI_SDO <= status_byte[bit_cnt_r[2:0]];
                else if (bit_cnt_r < `FRAME_BITS)
                    SPI_SDO <= tx_r[bit_cnt_r[2:0]];
            end
        end
    end

    // =================================================================
    // Register update logic.
    // =================================================================
    // Priority: soft reset, restart, fail-safe, low-power entries, stop exit, then
    // host writes. A mode event always wins over a write in the same
    // cycle because it reflects a state the device has already entered.
    always @*
    begin
        wdog_config_nxt = wdog_config_r;
        xcvr_mode_nxt = xcvr_mode_r;
        int_wake_nxt = int_wake_r;
        ext_wake_nxt = ext_wake_r;
        if (SOFT_RESET || !init_done_r)
        begin
            wdog_config_nxt = `RST_WDOG_CONFIG;
            xcvr_mode_nxt = `RST_XCVR_MODE;
            if (DEV_MODE)
                xcvr_mode_nxt = {5'h00, `DEV_XCVR_MODE};
            int_wake_nxt = `RST_INT_WAKE;
            ext_wake_nxt = `RST_EXT_WAKE;
        end
        else if (RESTART_ENTRY)
        begin
            wdog_config_nxt = (wdog_config_r & `RESTART_KEEP_WDOG)
                | `RESTART_SET_WDOG;
            // The cause sets the mode, the selective wake bit is kept.
            xcvr_mode_nxt = {5'h00, xcvr_mode_r[`SELWAKE_BIT],
                RESTART_XCVR_MODE[1:0]};
            int_wake_nxt = int_wake_r & `RESTART_KEEP_INT;
            ext_wake_nxt = ext_wake_r & `RESTART_KEEP_EXT;
        end
        else if (FAILSAFE_ENTRY)
        begin
            xcvr_mode_nxt = {5'h00, xcvr_mode_r[`SELWAKE_BIT],
                `XCVR_WAKE_CAPABLE};
            if (!ext_wake_r[`EWK_SENSE_BIT])
            begin
                ext_wake_nxt = (ext_wake_r & 8'hA0)
                    | 8'h01;
            end
        end
        else if (SLEEP_ENTRY)
        begin
            // Receive only always drops to wake capable on Sleep; normal
            // does so only without a pending system error.
            if (xcvr_mode_r[1:0] == `XCVR_RX_ONLY)
                xcvr_mode_nxt[1:0] = `XCVR_WAKE_CAPABLE;
            else if (xcvr_mode_r[1:0] == `XCVR_NORMAL
                && !SYSTEM_ERROR_FLAG)
                xcvr_mode_nxt[1:0] = `XCVR_WAKE_CAPABLE;
            // Off and wake capable fall through unchanged.
        end
        else if (STOP_ENTRY)
        begin
            // Stop keeps every transceiver setting, receive only included;
            // the host must have chosen it beforehand.
            xcvr_mode_nxt = xcvr_mode_r;
        end
        else if (STOP_TO_NORMAL)
        begin
            int_wake_nxt[`IWK_STOP_HI_BIT] = 1'b0;
        end
        else if (write_ok)
        begin
            case (wr_addr)
                `ADDR_WDOG_CONFIG:
                begin
                    // Odd parity marks a corrupted write.
                    if (!odd_parity(wr_data))
                        wdog_config_nxt = wr_data & `MASK_WDOG_CONFIG;
                end
                `ADDR_XCVR_MODE:
                    xcvr_mode_nxt = wr_data & `MASK_XCVR_MODE;
                `ADDR_INT_WAKE:
                    int_wake_nxt = wr_data & `MASK_INT_WAKE;
                `ADDR_EXT_WAKE:
                    ext_wake_nxt = wr_data & `MASK_EXT_WAKE;
                default:
                begin
                    // Unmapped addresses are ignored.
                    xcvr_mode_nxt = xcvr_mode_r;
                end
            endcase
        end
    end

    // Register storage and the init flag. Reset loads constants only; the
    // development strap is applied on the first edge after release.
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            init_done_r <= 1'b0;
            wdog_config_r <= `RST_WDOG_CONFIG;
            xcvr_mode_r <= `RST_XCVR_MODE;
            int_wake_r <= `RST_INT_WAKE;
            ext_wake_r <= `RST_EXT_WAKE;
        end
        else
        begin
            init_done_r <= 1'b1;
            wdog_config_r <= wdog_config_nxt;
            xcvr_mode_r <= xcvr_mode_nxt;
            int_wake_r <= int_wake_nxt;
            ext_wake_r <= ext_wake_nxt;
        end
    end

    // =================================================================
    // Configuration outputs and event gating.
    // =================================================================
    // Every output is registered, so consumers see a one-cycle lag.
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            WDOG_WINDOW_SELECT <= 1'b0;
            WDOG_PERIOD_SELECT <= 3'h4;
            WDOG_STOP_DISABLE <= 1'b0;
            WDOG_BUS_WAKE_START <= 1'b0;
            WDOG_PARITY_ERROR <= 1'b0;
            XCVR_MODE <= 3'h0;
            TIMER_WAKE <= 1'b0;
            WAKE_PIN_WAKE <= 1'b0;
            WAKE_PIN_SENSE_ON <= 1'b0;
            INTERRUPT_OUT_N <= 1'b1;
        end
        else
        begin
            WDOG_WINDOW_SELECT <= wdog_config_r[`WD_WINDOW_BIT];
            WDOG_PERIOD_SELECT <= wdog_config_r[`WD_PERIOD_HI:0];
            // Both request bits are needed to stop the watchdog.
            WDOG_STOP_DISABLE <= wdog_config_r[`WD_STOP_LO_BIT]
                && int_wake_r[`IWK_STOP_HI_BIT];
            // Bus wake starts the watchdog only if enabled.
            WDOG_BUS_WAKE_START <= BUS_WAKE_EVENT
                && wdog_config_r[`WD_BUS_WAKE_BIT];
            WDOG_PARITY_ERROR <= write_ok
                && (wr_addr == `ADDR_WDOG_CONFIG)
                && odd_parity(wr_data);
            XCVR_MODE <= xcvr_mode_r[2:0];
            TIMER_WAKE <= TIMER_WAKE_EVENT
                && int_wake_r[`IWK_TIMER_BIT];
            // Voltage sensing suppresses pin wake events.
            WAKE_PIN_WAKE <= WAKE_PIN_EVENT
                && ext_wake_r[`EWK_ENABLE_BIT]
                && !ext_wake_r[`EWK_SENSE_BIT];
            WAKE_PIN_SENSE_ON <= ext_wake_r[`EWK_SENSE_BIT];
            // Global routing lets any status bit pull the line low.
            INTERRUPT_OUT_N <= !(WAKE_PENDING
                || (ext_wake_r[`EWK_GLOBAL_BIT] && STATUS_PENDING));
        end
    end

endmodule // wake_ctrl_regs

`default_nettype wire

// file: verif/wake_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ========
// Port checker for the wake control register bank.
module wake_ctrl_monitor
(
    input wire CLK,
    input wire ARST_N,
    input wire SOFT_RESET,
    input wire RESTART_ENTRY,
    input wire [2:0] RESTART_XCVR_MODE,
    input wire FAILSAFE_ENTRY,
    input wire SLEEP_ENTRY,
    input wire STOP_ENTRY,
    input wire STOP_TO_NORMAL,
    input wire SYSTEM_ERROR_FLAG,
    input wire DEV_MODE,
    input wire BUS_WAKE_EVENT,
    input wire TIMER_WAKE_EVENT,
    input wire WAKE_PIN_EVENT,
    input wire STATUS_PENDING,
    input wire WAKE_PENDING,
    input wire WDOG_WINDOW_SELECT,
    input wire [2:0] WDOG_PERIOD_SELECT,
    input wire WDOG_STOP_DISABLE,
    input wire WDOG_BUS_WAKE_START,
    input wire WDOG_PARITY_ERROR,
    input wire [2:0] XCVR_MODE,
    input wire TIMER_WAKE,
    input wire WAKE_PIN_WAKE,
    input wire WAKE_PIN_SENSE_ON,
    input wire INTERRUPT_OUT_N
);
    // Strobes that win over sleep and stop handling.
    wire hi_prio;
    assign hi_prio = SOFT_RESET | RESTART_ENTRY | FAILSAFE_ENTRY;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // Mode entries that are not masked by a stronger strobe.
    sequence sleep_s;
        SLEEP_ENTRY && !SYSTEM_ERROR_FLAG && !hi_prio;
    endsequence
    sequence stop_s;
        STOP_ENTRY && !SLEEP_ENTRY && !hi_prio;
    endsequence
    sequence fs_s;
        FAILSAFE_ENTRY && !SOFT_RESET && !RESTART_ENTRY;
    endsequence
    bus_wake_start_a: assert property (
        WDOG_BUS_WAKE_START |-> $past(BUS_WAKE_EVENT))
        else $error("bus wake start without event");
    timer_wake_gate_a: assert property (
        TIMER_WAKE |-> $past(TIMER_WAKE_EVENT))
        else $error("timer wake without event");
    pin_wake_gate_a: assert property (
        WAKE_PIN_WAKE |-> $past(WAKE_PIN_EVENT) && !WAKE_PIN_SENSE_ON)
        else $error("pin wake while sensing or without event");
    wake_irq_a: assert property (
        $past(WAKE_PENDING) |-> !INTERRUPT_OUT_N)
        else $error("wake pending did not raise interrupt");
    quiet_irq_a: assert property (
        !$past(WAKE_PENDING) && !$past(STATUS_PENDING) |-> INTERRUPT_OUT_N)
        else $error("interrupt with nothing pending");
    stop_exit_a: assert property (
        STOP_TO_NORMAL |-> ##2 !WDOG_STOP_DISABLE)
        else $error("stop disable kept after stop exit");
    sleep_xcvr_a: assert property (
        sleep_s |-> ##2 (!XCVR_MODE[1] && XCVR_MODE[2] == $past(XCVR_MODE[2])))
        else $error("transceiver wrong after sleep");
    stop_xcvr_a: assert property (
        stop_s |-> ##2 $stable(XCVR_MODE))
        else $error("transceiver changed on stop");
    failsafe_xcvr_a: assert property (
        fs_s |-> ##2 (XCVR_MODE[1:0] == 2'h1 && XCVR_MODE[2] == $past(XCVR_MODE[2])))
        else $error("transceiver wrong after fail-safe");
    restart_vals_a: assert property (
        RESTART_ENTRY && !SOFT_RESET |-> ##2
        (XCVR_MODE[1:0] == $past(RESTART_XCVR_MODE[1:0], 2) &&
         WDOG_PERIOD_SELECT == 3'h4 && !WDOG_STOP_DISABLE))
        else $error("restart values wrong");
    soft_vals_a: assert property (
        SOFT_RESET |-> ##2 (WDOG_PERIOD_SELECT == 3'h4 && !WDOG_WINDOW_SELECT
        && XCVR_MODE == ($past(DEV_MODE, 2) ? 3'h3 : 3'h0)))
        else $error("soft reset values wrong");
    parity_hold_a: assert property (
        WDOG_PARITY_ERROR |=> $stable(WDOG_PERIOD_SELECT) &&
        $stable(WDOG_WINDOW_SELECT))
        else $error("odd parity write changed watchdog");
endmodule // wake_ctrl_monitor

bind wake_ctrl_regs wake_ctrl_monitor i_wake_ctrl_monitor (.CLK(CLK),
    .ARST_N(ARST_N), .SOFT_RESET(SOFT_RESET), .RESTART_ENTRY(RESTART_ENTRY),
    .RESTART_XCVR_MODE(RESTART_XCVR_MODE), .FAILSAFE_ENTRY(FAILSAFE_ENTRY),
    .SLEEP_ENTRY(SLEEP_ENTRY), .STOP_ENTRY(STOP_ENTRY),
    .STOP_TO_NORMAL(STOP_TO_NORMAL), .SYSTEM_ERROR_FLAG(SYSTEM_ERROR_FLAG),
    .DEV_MODE(DEV_MODE), .BUS_WAKE_EVENT(BUS_WAKE_EVENT),
    .TIMER_WAKE_EVENT(TIMER_WAKE_EVENT), .WAKE_PIN_EVENT(WAKE_PIN_EVENT),
    .STATUS_PENDING(STATUS_PENDING), .WAKE_PENDING(WAKE_PENDING),
    .WDOG_WINDOW_SELECT(WDOG_WINDOW_SELECT),
    .WDOG_PERIOD_SELECT(WDOG_PERIOD_SELECT),
    .WDOG_STOP_DISABLE(WDOG_STOP_DISABLE),
    .WDOG_BUS_WAKE_START(WDOG_BUS_WAKE_START),
    .WDOG_PARITY_ERROR(WDOG_PARITY_ERROR), .XCVR_MODE(XCVR_MODE),
    .TIMER_WAKE(TIMER_WAKE), .WAKE_PIN_WAKE(WAKE_PIN_WAKE),
    .WAKE_PIN_SENSE_ON(WAKE_PIN_SENSE_ON), .INTERRUPT_OUT_N(INTERRUPT_OUT_N));
`default_nettype wire

// file: verif/spi_host.sv
`timescale 1ns/10ps
`default_nettype none
// ========
// Microcontroller side of the serial link: one 16-bit frame per call.
module spi_host
(
    input wire logic clk,
    input wire logic sdo,
    output logic cs_n,
    output logic sck,
    output logic sdi
);
    // Idle link: deselected, clock parked low.
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // Address first, least significant bit first; half period 5 cycles.
    task automatic xfer(input logic [6:0] a, input logic w,
        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        begin
            f = {d, w, a};
            q = 8'h00;
            @(posedge clk);
            #1 cs_n = 1'b0;
            for (int i = 0; i < 16; i++)
            begin
                sdi = f[i];
                repeat (5) @(posedge clk);
                #1 sck = 1'b1;
                if (i >= 8)
                    q[i-8] = sdo;
                repeat (5) @(posedge clk);
                #1 sck = 1'b0;
            end
            repeat (5) @(posedge clk);
            #1 cs_n = 1'b1;
            // A released line must not keep showing the last bit.
            sdi = ~sdi;
            // Gap covers the commit delay and the frame spacing.
            repeat (8) @(posedge clk);
        end
    endtask
endmodule // spi_host
`default_nettype wire

// file: verif/wake_ctrl_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ========
// Register bank bench driven through the serial link.
module wake_ctrl_regs_tb;
    logic clk, arst_n, system_error_flag, dev, stat_p, wake_p;
    logic [5:0] strb; // Soft, restart, fail-safe, sleep, stop, exit.
    logic [2:0] ev; // Bus, timer, pin wake events.
    logic [2:0] rmode;
    logic [7:0] q;
    wire cs_n, sck, sdi, sdo, wwin, wstop, wbus, wperr, twake, pwake;
    wire psense, irq_n, oe_n;
    wire [2:0] wper, xmode;
    int num_errors, checked, n_perr, n_bus, n_tmr, n_pin, n_oe;
    wake_ctrl_regs i_wake_ctrl_regs (.CLK(clk), .ARST_N(arst_n),
        .SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_SDI(sdi), .SPI_SDO(sdo),
        .SPI_SDO_OE_N(oe_n), .SOFT_RESET(strb[5]), .RESTART_ENTRY(strb[4]),
        .RESTART_XCVR_MODE(rmode), .FAILSAFE_ENTRY(strb[3]),
        .SLEEP_ENTRY(strb[2]), .STOP_ENTRY(strb[1]),
        .STOP_TO_NORMAL(strb[0]), .SYSTEM_ERROR_FLAG(system_error_flag),
        .DEV_MODE(dev), .BUS_WAKE_EVENT(ev[2]), .TIMER_WAKE_EVENT(ev[1]),
        .WAKE_PIN_EVENT(ev[0]), .STATUS_PENDING(stat_p),
        .WAKE_PENDING(wake_p), .WDOG_WINDOW_SELECT(wwin),
        .WDOG_PERIOD_SELECT(wper), .WDOG_STOP_DISABLE(wstop),
        .WDOG_BUS_WAKE_START(wbus), .WDOG_PARITY_ERROR(wperr),
        .XCVR_MODE(xmode), .TIMER_WAKE(twake), .WAKE_PIN_WAKE(pwake),
        .WAKE_PIN_SENSE_ON(psense), .INTERRUPT_OUT_N(irq_n));
    spi_host i_spi_host (.clk(clk), .sdo(sdo), .cs_n(cs_n), .sck(sck),
        .sdi(sdi));
    // 125 MHz clock.
    always #4 clk = ~clk;
    // Pulse counters: a one-cycle output is caught in its own cycle.
    always @(posedge clk)
    begin
        if (wperr === 1'b1) n_perr++;
        if (wbus === 1'b1) n_bus++;
        if (twake === 1'b1) n_tmr++;
        if (pwake === 1'b1) n_pin++;
        if (oe_n === 1'b0) n_oe++;
    end
    task close_out;
        begin
            $display("checked=%0d num_errors=%0d", checked, num_errors);
            if (num_errors == 0 && checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [7:0] got, input logic [7:0] e);
        begin
            checked++;
            if (got !== e)
            begin
                num_errors++;
                $display("MISMATCH %s expected %h seen %h", nm, e, got);
            end
        end
    endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        i_spi_host.xfer(a, 1'b1, d, q);
    endtask
    task rd(input logic [6:0] a, input logic [7:0] e);
        begin
            i_spi_host.xfer(a, 1'b0, 8'h00, q);
            chk($sformatf("reg %h", a), q, e);
        end
    endtask
    // One-cycle strobe; k picks the mode strobe or, above 5, an event.
    task pulse(input int k);
        begin
            @(posedge clk);
            #1 if (k > 5) ev[k-6] = 1'b1; else strb[k] = 1'b1;
            @(posedge clk);
            #1 strb = 6'h00;
            ev = 3'h0;
            repeat (3) @(posedge clk);
        end
    endtask
    // Hang guard.
    initial
    begin
        repeat (100000) @(posedge clk);
        num_errors++;
        close_out;
    end
    initial
    begin
        clk = 0; arst_n = 0; system_error_flag = 0; dev = 0; stat_p = 0; wake_p = 0;
        strb = 6'h00; ev = 3'h0; rmode = 3'h0;
        repeat (4) @(posedge clk);
        #1 arst_n = 1;
        repeat (6) @(posedge clk);
        rd(7'h03, 8'h14);
        rd(7'h04, 8'h00);
        rd(7'h06, 8'h00);
        rd(7'h07, 8'h01);
        chk("period", {5'h00, wper}, 8'h04);
        chk("sdo off", {7'h00, oe_n}, 8'h01);
        chk("sdo on", {7'h00, n_oe > 0}, 8'h01);
        wr(7'h03, 8'hFF);
        wr(7'h04, 8'hFF);
        wr(7'h06, 8'hFF);
        wr(7'h07, 8'hFF);
        wr(7'h05, 8'h00);
        rd(7'h03, 8'hF7);
        rd(7'h04, 8'h07);
        rd(7'h06, 8'h44);
        rd(7'h07, 8'hA1);
        chk("stop off", {7'h00, wstop}, 8'h01);
        chk("sense", {7'h00, psense}, 8'h01);
        wr(7'h03, 8'h01);
        chk("parity", n_perr[7:0], 8'h01);
        rd(7'h03, 8'hF7);
        wr(7'h03, 8'h21);
        chk("stop off", {7'h00, wstop}, 8'h00);
        chk("window", {7'h00, wwin}, 8'h01);
        chk("period", {5'h00, wper}, 8'h01);
        wr(7'h03, 8'h41);
        chk("stop off", {7'h00, wstop}, 8'h01);
        chk("window", {7'h00, wwin}, 8'h00);
        for (int v = 0; v < 8; v++)
        begin
            wr(7'h04, v[7:0]);
            chk("xcvr", {5'h00, xmode}, v[7:0]);
            pulse(2);
            chk("xcvr", {5'h00, xmode},
                v[1] ? {5'h00, v[2], 2'h1} : v[7:0]);
            wr(7'h04, v[7:0]);
            pulse(1);
            chk("xcvr", {5'h00, xmode}, v[7:0]);
        end
        @(posedge clk);
        #1 system_error_flag = 1;
        wr(7'h04, 8'h03);
        pulse(2);
        chk("xcvr", {5'h00, xmode}, 8'h03);
        @(posedge clk);
        #1 system_error_flag = 0;
        wr(7'h04, 8'h06);
        wr(7'h07, 8'h80);
        pulse(3);
        rd(7'h04, 8'h05);
        rd(7'h07, 8'h81);
        wr(7'h07, 8'hA0);
        pulse(3);
        rd(7'h07, 8'hA0);
        pulse(0);
        rd(7'h06, 8'h40);
        wr(7'h06, 8'h44);
        wr(7'h03, 8'hFF);
        wr(7'h07, 8'hFF);
        wr(7'h04, 8'h07);
        #1 rmode = 3'h2;
        pulse(4);
        rd(7'h03, 8'hB4);
        rd(7'h04, 8'h06);
        rd(7'h06, 8'h40);
        rd(7'h07, 8'hA1);
        #1 dev = 1;
        pulse(5);
        rd(7'h04, 8'h03);
        rd(7'h03, 8'h14);
        rd(7'h06, 8'h00);
        rd(7'h07, 8'h01);
        #1 dev = 0;
        wr(7'h06, 8'h40);
        for (int k = 6; k < 9; k++) pulse(k);
        chk("bus wake", n_bus[7:0], 8'h01);
        chk("timer wake", n_tmr[7:0], 8'h01);
        chk("pin wake", n_pin[7:0], 8'h01);
        wr(7'h07, 8'h21);
        wr(7'h03, 8'h21);
        wr(7'h06, 8'h00);
        for (int k = 6; k < 9; k++) pulse(k);
        chk("bus wake", n_bus[7:0], 8'h01);
        chk("timer wake", n_tmr[7:0], 8'h01);
        chk("pin wake", n_pin[7:0], 8'h01);
        @(posedge clk);
        #1 stat_p = 1;
        repeat (3) @(posedge clk);
        chk("irq", {7'h00, irq_n}, 8'h01);
        wr(7'h07, 8'h80);
        chk("irq", {7'h00, irq_n}, 8'h00);
        #1 stat_p = 0;
        wake_p = 1;
        repeat (3) @(posedge clk);
        chk("irq", {7'h00, irq_n}, 8'h00);
        close_out;
    end
endmodule // wake_ctrl_regs_tb
`default_nettype wire
